//--- shared/mss_pkg.sv
// package: constants, states and carrier types of the startup sequencer
package mss_pkg;
    localparam int CLK_MHZ       = 100;
    // register byte offsets
    localparam logic [7:0] RUN_CTRL_OFS  = 8'h00;
    localparam logic [7:0] SPEED_CFG_OFS = 8'h04;
    localparam logic [7:0] START_CFG_OFS = 8'h08;
    localparam logic [7:0] LEVEL_CFG_OFS = 8'h0C;
    localparam logic [7:0] STATUS_OFS    = 8'h10;
    localparam logic [7:0] REF_SPD_OFS   = 8'h14;
    // run control fields
    localparam int RUN_BIT = 0;
    localparam int DIR_BIT = 1;
    localparam int STM_BIT = 2;
    // speed config fields
    localparam int SU_LSB  = 0;
    localparam int SR_LSB  = 4;
    localparam int SCS_BIT = 16;
    localparam int TRS_BIT = 17;
    localparam int KI_LSB  = 18;
    // startup config fields
    localparam int HR_LSB  = 0;
    localparam int HT_LSB  = 4;
    localparam int HD_LSB  = 10;
    localparam int STS_LSB = 14;
    localparam int STD_LSB = 19;
    localparam int WMT_LSB = 24;
    // level config fields
    localparam int VST_LSB = 0;
    localparam int ILIM_LSB = 10;
    // reset values
    localparam logic [31:0] RUN_CTRL_RST  = 32'h0000_0000;
    localparam logic [31:0] SPEED_CFG_RST = 32'h0000_0011;
    localparam logic [31:0] START_CFG_RST = 32'h0000_000F;
    localparam logic [31:0] LEVEL_CFG_RST = 32'h000F_A020;
    // timing
    localparam int INIT_US      = 10;
    localparam int INIT_CYC     = INIT_US * CLK_MHZ;
    localparam int STEP_US      = 10;
    localparam int STEP_CYC     = STEP_US * CLK_MHZ;
    localparam int BOOT_US      = 100;
    localparam int BOOT_CYC     = BOOT_US * CLK_MHZ;
    localparam int UCB_SKIP_MS  = 200;
    localparam int UCB_SKIP_CYC = UCB_SKIP_MS * 1000 * CLK_MHZ;
    localparam int HOLD_UNIT_MS = 10;
    localparam int HOLD_UNIT_CYC = HOLD_UNIT_MS * 1000 * CLK_MHZ;
    localparam int RAMP_S       = 5;
    localparam int RAMP_STEPS   = 96;
    // one ramp step at code 15 is sixteen times this
    localparam int RAMP_SUB_CYC = RAMP_S * 1000000 * CLK_MHZ
                                  / (RAMP_STEPS * 16);
    localparam logic [6:0] DUTY_FULL  = 7'h64;
    localparam logic [7:0] RAMP_START = 8'h20;
    localparam logic [7:0] RAMP_LAST  = 8'h80;

    typedef enum logic [6:0] {
        S_OFF   = 7'h01,
        S_UCBRK = 7'h02,
        S_BOOT  = 7'h04,
        S_WMBRK = 7'h08,
        S_HOLD  = 7'h10,
        S_DRIVE = 7'h20,
        S_RUN   = 7'h40
    } mss_state_t;

    typedef struct packed {
        logic        all_off;
        logic        low_brake;
        logic [6:0]  low_duty;
        logic [7:0]  dc_ref;
        logic        open_loop;
        logic [13:0] excite_speed;
        logic        reverse;
        logic [15:0] torque;
    } mss_drive_t;
endpackage

//--- core/mss_tach.sv
// speed pulse generator at one or three pulses per electrical cycle
`timescale 1ns/1ps
`default_nettype none
module mss_tach
    import mss_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic sector_tick,
    input  wire logic enable,
    input  wire logic rate_x3,
    output var  logic pulse
);
    logic [1:0] sector_r;
    logic [1:0] sector_nxt;
    logic       pulse_nxt;
    wire        wrap = (sector_r == 2'h2);

    assign sector_nxt = !enable ? 2'h0 :
                        !sector_tick ? sector_r :
                        wrap ? 2'h0 : sector_r + 2'h1;
    // three sector ticks make one electrical cycle
    assign pulse_nxt = enable && sector_tick
                       && (rate_x3 || sector_r == 2'h0);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sector_r <= 2'h0;
            pulse    <= 1'b0;
        end else begin
            sector_r <= sector_nxt;
            pulse    <= pulse_nxt;
        end
    end
endmodule // mss_tach
`default_nettype wire

//--- core/mss_top.sv
// startup sequencer, speed loop front end and apb register file
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - speed pulses at one or three per electrical cycle, by tach rate bit
// - speed pulses only while commutation is synchronized with rotation
// - reference minus feedback speed is integrated into a torque reference
// - reference speed from register value or speed voltage, by select bit
// - four-bit range multiplier and ten-bit reference speed code held
// - four-bit gain code scales the integral gain
// - startup method bit picks dc alignment or ramp-up start
// - brake with low sides on, duty rising to 100% under current limit
// - braking ends once duty is at 100% and detected current has fallen to the windmill stop threshold
// - alignment ramps dc current to hold level, keeps it for hold time
// - after hold, closed-loop run starting from startup duty
// - ramp-up raises excitation speed from 25% to 100% over about 5 s at ramp period code 15
// - at full startup speed switch to estimated position, closed loop
// - ramp period, hold time, hold current, speed and duty codes held
// - modes brake, all off, bootstrap, windmill, hold, drive and run
// - user brake skipped when speed voltage crosses range under 200 ms
// - run bit low forces all switches off and coasting over all else
// - windmill braking ends when duty is at 100% and current is at or below its threshold
// - direction is register bit xor direction pin, both low forward
module mss_top
    import mss_pkg::*;
#(
    parameter int UCB_CYC  = UCB_SKIP_CYC,
    parameter int BOOTC    = BOOT_CYC,
    parameter int HOLD_CYC = HOLD_UNIT_CYC,
    parameter int RAMP_CYC = RAMP_SUB_CYC,
    parameter int STEP_LEN = STEP_CYC
)
(
    input  wire logic        CLK,
    input  wire logic        RST_B,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output var  logic [31:0] PRDATA,
    output var  logic        PREADY,
    output var  logic        PSLVERR,
    input  wire logic [9:0]  SPEED_VOLTAGE_IN,
    input  wire logic [9:0]  MOTOR_CURRENT,
    input  wire logic [13:0] FEEDBACK_SPEED,
    input  wire logic        DIR_PIN,
    input  wire logic        SYNC_OK,
    input  wire logic        SECTOR_TICK,
    output var  mss_drive_t  DRIVE,
    output var  logic [6:0]  SEQ_STATE,
    output var  logic        SPEED_PULSE_OUT
);
    logic [31:0] run_ctrl_r, speed_cfg_r, start_cfg_r, level_cfg_r;
    mss_state_t  state_r, state_nxt;
    logic [31:0] cnt_r, cnt_nxt, uc_cnt_r, step_r;
    logic [6:0]  duty_r, duty_nxt;
    logic [7:0]  prog_r, prog_nxt;
    logic [7:0]  dc_r, dc_nxt;
    logic [15:0] acc_r, acc_nxt;
    logic [13:0] ref_r;
    mss_drive_t  drive_nxt;
    logic [31:0] rdata_nxt;

    // configuration fields
    wire       run_en    = run_ctrl_r[RUN_BIT];
    wire       dir_bit   = run_ctrl_r[DIR_BIT];
    wire       startup_method_select = run_ctrl_r[STM_BIT];
    wire [3:0] speed_range_multiplier = speed_cfg_r[SU_LSB +: 4];
    wire [9:0] reference_speed_code   = speed_cfg_r[SR_LSB +: 10];
    wire       speed_source_select    = speed_cfg_r[SCS_BIT];
    wire       tach_rate_select       = speed_cfg_r[TRS_BIT];
    wire [3:0] ki_code                = speed_cfg_r[KI_LSB +: 4];
    wire [3:0] ramp_period_code  = start_cfg_r[HR_LSB +: 4];
    wire [5:0] hold_time_code    = start_cfg_r[HT_LSB +: 6];
    wire [3:0] hold_current_code = start_cfg_r[HD_LSB +: 4];
    wire [4:0] startup_speed_code = start_cfg_r[STS_LSB +: 5];
    wire [4:0] startup_duty_code  = start_cfg_r[STD_LSB +: 5];
    wire [1:0] windmill_stop_threshold = start_cfg_r[WMT_LSB +: 2];
    wire [9:0] start_volt = level_cfg_r[VST_LSB +: 10];
    wire [9:0] brake_ilim = level_cfg_r[ILIM_LSB +: 10];

    // apb decode; the slave answers one cycle after setup
    wire setup   = PSEL && !PENABLE;
    wire acc_cyc = PSEL && PENABLE && PREADY;
    wire wr_en   = acc_cyc && PWRITE;
    wire hit_run = PADDR == RUN_CTRL_OFS;
    wire hit_spd = PADDR == SPEED_CFG_OFS;
    wire hit_st  = PADDR == START_CFG_OFS;
    wire hit_lvl = PADDR == LEVEL_CFG_OFS;
    wire hit_sta = PADDR == STATUS_OFS;
    wire hit_ref = PADDR == REF_SPD_OFS;
    wire mapped  = hit_run | hit_spd | hit_st | hit_lvl | hit_sta | hit_ref;
    wire [31:0] status_w = {DRIVE.torque, 7'h00, DRIVE.open_loop, 1'b0, state_r};

    assign rdata_nxt = hit_run ? run_ctrl_r :
                       hit_spd ? speed_cfg_r :
                       hit_st  ? start_cfg_r :
                       hit_lvl ? level_cfg_r :
                       hit_sta ? status_w :
                       hit_ref ? {18'h0, ref_r} : 32'h0000_0000;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0000_0000;
        end else begin
            PREADY  <= setup;
            PSLVERR <= setup && !mapped;
            PRDATA  <= setup && !PWRITE ? rdata_nxt : 32'h0000_0000;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            run_ctrl_r  <= RUN_CTRL_RST;
            speed_cfg_r <= SPEED_CFG_RST;
            start_cfg_r <= START_CFG_RST;
            level_cfg_r <= LEVEL_CFG_RST;
        end else if (wr_en) begin
            if (hit_run) run_ctrl_r  <= {29'h0, PWDATA[2:0]};
            if (hit_spd) speed_cfg_r <= {10'h0, PWDATA[21:0]};
            if (hit_st)  start_cfg_r <= {6'h0, PWDATA[25:0]};
            if (hit_lvl) level_cfg_r <= {12'h0, PWDATA[19:0]};
        end
    end

    // reference speed, range multiplier times code from either source
    wire [9:0]  ref_code = speed_source_select ? reference_speed_code
                                               : SPEED_VOLTAGE_IN;
    wire [13:0] ref_nxt  = ref_code * speed_range_multiplier;

    // sequencing conditions
    wire step_tick = step_r == 32'(STEP_LEN - 1);
    wire in_ucb    = !speed_source_select && SPEED_VOLTAGE_IN <= start_volt;
    wire [9:0] wm_lvl = {2'h0, windmill_stop_threshold, 6'h00};
    wire wm_done   = duty_r == DUTY_FULL
                     && MOTOR_CURRENT <= wm_lvl;
    wire [7:0]  hold_lvl  = {hold_current_code, 4'h0};
    wire [31:0] hold_len  = 32'(hold_time_code) * 32'(HOLD_CYC);
    wire [31:0] ramp_len  = 32'(ramp_period_code + 5'h1) * 32'(RAMP_CYC);
    wire [9:0]  ss_full   = {startup_speed_code, 5'h00};
    wire [17:0] exc_prod  = ss_full * prog_r;
    wire [15:0] preset    = {startup_duty_code, 11'h000};

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r + 32'h1;
        duty_nxt  = duty_r;
        dc_nxt    = dc_r;
        prog_nxt  = prog_r;
        unique case (state_r)
            S_OFF: begin
                // init first, then decide whether user brake is worth it
                if (cnt_r >= 32'(INIT_CYC - 1)) begin
                    cnt_nxt = cnt_r;
                    if (!in_ucb)
                        state_nxt = S_BOOT;
                    else if (uc_cnt_r >= 32'(UCB_CYC))
                        state_nxt = S_UCBRK;
                end
            end
            S_UCBRK: begin
                duty_nxt = DUTY_FULL;
                if (!in_ucb) state_nxt = S_BOOT;
            end
            S_BOOT: begin
                duty_nxt = 7'h00;
                if (cnt_r >= 32'(BOOTC - 1)) state_nxt = S_WMBRK;
            end
            S_WMBRK: begin
                // current limited duty ramp toward full braking
                if (step_tick) begin
                    if (MOTOR_CURRENT < brake_ilim && duty_r < DUTY_FULL)
                        duty_nxt = duty_r + 7'h01;
                    else if (MOTOR_CURRENT >= brake_ilim && duty_r != 7'h00)
                        duty_nxt = duty_r - 7'h01;
                end
                if (wm_done)
                    state_nxt = startup_method_select ? S_DRIVE : S_HOLD;
                if (wm_done) prog_nxt = RAMP_START;
            end
            S_HOLD: begin
                duty_nxt = 7'h00;
                if (dc_r < hold_lvl) begin
                    cnt_nxt = 32'h0;
                    if (step_tick) dc_nxt = dc_r + 8'h01;
                end else if (cnt_r >= hold_len) begin
                    state_nxt = S_RUN;
                end
            end
            S_DRIVE: begin
                duty_nxt = 7'h00;
                dc_nxt   = {startup_duty_code, 3'h0};
                if (cnt_r >= ramp_len - 32'h1) begin
                    cnt_nxt = 32'h0;
                    prog_nxt = prog_r + 8'h01;
                    if (prog_nxt >= RAMP_LAST) state_nxt = S_RUN;
                end
            end
            S_RUN: begin
                duty_nxt = 7'h00;
                dc_nxt   = 8'h00;
            end
            default: state_nxt = S_OFF;
        endcase
        if (!run_en) state_nxt = S_OFF;
        if (state_nxt != state_r) cnt_nxt = 32'h0;
        if (state_nxt == S_OFF) begin
            duty_nxt = 7'h00;
            dc_nxt   = 8'h00;
        end
    end

    // integrating speed controller, updated once per step tick
    wire signed [14:0] err  = $signed({1'b0, ref_r})
                              - $signed({1'b0, FEEDBACK_SPEED});
    wire signed [19:0] inc  = err * $signed({2'b00, ki_code} + 6'h01);
    wire signed [20:0] sum  = $signed({5'h00, acc_r}) + 21'(inc);
    wire [15:0] sum_sat = sum < 0 ? 16'h0000 :
                          sum > 21'sh00FFFF ? 16'hFFFF : sum[15:0];

    assign acc_nxt = state_r != S_RUN ? preset :
                     step_tick ? sum_sat : acc_r;

    always_comb begin
        drive_nxt              = '0;
        drive_nxt.all_off      = state_nxt == S_OFF
                                 || state_nxt == S_BOOT && cnt_nxt == 0;
        drive_nxt.low_brake    = state_nxt == S_UCBRK
                                 || state_nxt == S_WMBRK
                                 || state_nxt == S_BOOT;
        drive_nxt.low_duty     = duty_nxt;
        drive_nxt.dc_ref       = dc_nxt;
        drive_nxt.open_loop    = state_nxt != S_RUN;
        drive_nxt.excite_speed = state_nxt == S_DRIVE ? {3'h0, exc_prod[17:7]}
                                 : state_nxt == S_RUN ? ref_r : 14'h0000;
        drive_nxt.reverse      = dir_bit ^ DIR_PIN;
        drive_nxt.torque       = state_nxt == S_RUN ? acc_nxt : 16'h0000;
        // run bit low overrides everything: coast
        if (state_nxt == S_OFF) begin
            drive_nxt.low_brake = 1'b0;
            drive_nxt.torque    = 16'h0000;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_r   <= S_OFF;
            cnt_r     <= 32'h0;
            uc_cnt_r  <= 32'h0;
            step_r    <= 32'h0;
            duty_r    <= 7'h00;
            dc_r      <= 8'h00;
            prog_r    <= 8'h00;
            acc_r     <= 16'h0000;
            ref_r     <= 14'h0000;
            DRIVE     <= '{all_off: 1'b1, default: '0};
            SEQ_STATE <= S_OFF;
        end else begin
            state_r   <= state_nxt;
            cnt_r     <= cnt_nxt;
            uc_cnt_r  <= in_ucb ? uc_cnt_r + 32'h1 : 32'h0;
            step_r    <= step_tick ? 32'h0 : step_r + 32'h1;
            duty_r    <= duty_nxt;
            dc_r      <= dc_nxt;
            prog_r    <= prog_nxt;
            acc_r     <= acc_nxt;
            ref_r     <= ref_nxt;
            DRIVE     <= drive_nxt;
            SEQ_STATE <= state_nxt;
        end
    end

    // pulses only while running in sync with the rotor
    wire tach_en = state_r == S_RUN && SYNC_OK;
    mss_tach u_tach (
        .clk         (CLK),
        .rst_b       (RST_B),
        .sector_tick (SECTOR_TICK),
        .enable      (tach_en),
        .rate_x3     (tach_rate_select),
        .pulse       (SPEED_PULSE_OUT)
    );

    a_run_low_coast: assert property (@(posedge CLK) disable iff (!RST_B)
        !run_en |=> state_r == S_OFF && DRIVE.all_off && !DRIVE.low_brake)
        else $error("run low did not force coast");
    a_pulse_needs_sync: assert property (@(posedge CLK) disable iff (!RST_B)
        SPEED_PULSE_OUT |-> $past(tach_en))
        else $error("speed pulse while not synchronized");
    a_x1_pulse_gap: assert property (@(posedge CLK) disable iff (!RST_B)
        SPEED_PULSE_OUT && !tach_rate_select ##1 tach_en && SECTOR_TICK
        && !tach_rate_select |=> !SPEED_PULSE_OUT)
        else $error("x1 rate pulsed on consecutive sectors");
    a_x3_every_tick: assert property (@(posedge CLK) disable iff (!RST_B)
        tach_en && SECTOR_TICK && tach_rate_select |=> SPEED_PULSE_OUT)
        else $error("x3 rate missed a sector pulse");
    a_brake_exit_zero: assert property (@(posedge CLK) disable iff (!RST_B)
        state_r == S_WMBRK ##1 state_r inside {S_HOLD, S_DRIVE}
        |-> $past(wm_done))
        else $error("windmill brake left with current flowing");
    a_method_select: assert property (@(posedge CLK) disable iff (!RST_B)
        state_r == S_WMBRK ##1 state_r == S_HOLD
        |-> !$past(startup_method_select))
        else $error("alignment start taken with ramp method selected");
    a_duty_ceiling: assert property (@(posedge CLK) disable iff (!RST_B)
        DRIVE.low_duty <= DUTY_FULL)
        else $error("brake duty above full scale");
    a_dir_xor: assert property (@(posedge CLK) disable iff (!RST_B)
        ##1 DRIVE.reverse == ($past(dir_bit) ^ $past(DIR_PIN)))
        else $error("direction not bit xor pin");
    a_integ_preset: assert property (@(posedge CLK) disable iff (!RST_B)
        state_r != S_RUN |=> acc_r == $past(preset))
        else $error("integrator not preset outside run");
    a_ref_source: assert property (@(posedge CLK) disable iff (!RST_B)
        ##1 ref_r == ($past(speed_source_select) ? $past(reference_speed_code)
                      : $past(SPEED_VOLTAGE_IN)) * $past(speed_range_multiplier))
        else $error("reference speed source mismatch");
endmodule // mss_top
`default_nettype wire

//--- tb/mss_motor_model.sv
// motor and power stage stand-in: brake current, speed and sector ticks
`timescale 1ns/1ps
`default_nettype none
module mss_motor_model
    import mss_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire mss_drive_t  drive,
    input  wire logic [6:0]  state,
    input  wire logic        overload,
    input  wire logic        lose_sync,
    output var  logic [9:0]  current,
    output var  logic [13:0] speed,
    output var  logic        sync_ok,
    output var  logic        tick
);
    logic [9:0] cur_r;
    logic [5:0] sec_cnt_r;
    // overload models a stalled rotor pushing the brake current past limit
    assign current = overload ? 10'h3FF : cur_r;
    assign sync_ok = (state == S_RUN) && !lose_sync;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cur_r <= 10'h064;
            speed <= '0;
            sec_cnt_r <= '0;
            tick <= 1'b0;
        end else begin
            // bemf only collapses once the low sides are fully on
            if (drive.low_duty == DUTY_FULL && cur_r != 10'h000) begin
                cur_r <= cur_r - 10'h001;
            end
            if (state == S_OFF) begin
                speed <= '0;
            end else if (drive.open_loop) begin
                speed <= drive.excite_speed;
            end
            sec_cnt_r <= (state == S_RUN && sec_cnt_r != 6'h31) ?
                         sec_cnt_r + 6'h01 : 6'h00;
            tick <= (state == S_RUN && sec_cnt_r == 6'h31);
        end
    end
endmodule // mss_motor_model
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench: apb access, startup walk, speed loop and pulses
`timescale 1ns/1ps
`default_nettype none
module testbench
    import mss_pkg::*;
;
    logic        CLK = 1'b0;
    logic        RST_B = 1'b0;
    logic        PSEL = 1'b0;
    logic        PENABLE = 1'b0;
    logic        PWRITE = 1'b0;
    logic [7:0]  PADDR = '0;
    logic [31:0] PWDATA = '0;
    logic [31:0] PRDATA;
    logic        PREADY;
    logic        PSLVERR;
    logic [9:0]  SPEED_VOLTAGE_IN = '0;
    logic [9:0]  MOTOR_CURRENT;
    logic [13:0] FEEDBACK_SPEED;
    logic        DIR_PIN = 1'b0;
    logic        SYNC_OK;
    logic        SECTOR_TICK;
    logic        SPEED_PULSE_OUT;
    logic        overload = 1'b0;
    logic        lose_sync = 1'b0;
    mss_drive_t  DRIVE;
    logic [6:0]  SEQ_STATE;
    logic [31:0] rd;
    logic [31:0] t0;
    logic        er;
    logic [6:0]  d0;
    int          n;
    int          mismatches = 0;
    int          checked = 0;
    int          cyc = 0;
    int          pulses = 0;
    logic [7:0]  ofs[3] = '{SPEED_CFG_OFS, START_CFG_OFS, LEVEL_CFG_OFS};
    logic [31:0] rst_v[3] = '{SPEED_CFG_RST, START_CFG_RST, LEVEL_CFG_RST};
    logic [31:0] msk[3] = '{32'h003F_FFFF, 32'h03FF_FFFF, 32'h000F_FFFF};

    mss_top #(.UCB_CYC(50), .BOOTC(20), .HOLD_CYC(10), .RAMP_CYC(2),
              .STEP_LEN(100)) dut_u (
        .CLK(CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR),
        .SPEED_VOLTAGE_IN(SPEED_VOLTAGE_IN), .MOTOR_CURRENT(MOTOR_CURRENT),
        .FEEDBACK_SPEED(FEEDBACK_SPEED), .DIR_PIN(DIR_PIN),
        .SYNC_OK(SYNC_OK), .SECTOR_TICK(SECTOR_TICK), .DRIVE(DRIVE),
        .SEQ_STATE(SEQ_STATE), .SPEED_PULSE_OUT(SPEED_PULSE_OUT));
    mss_motor_model motor_u (
        .clk(CLK), .rst_b(RST_B), .drive(DRIVE), .state(SEQ_STATE),
        .overload(overload), .lose_sync(lose_sync),
        .current(MOTOR_CURRENT), .speed(FEEDBACK_SPEED),
        .sync_ok(SYNC_OK), .tick(SECTOR_TICK));

    always #5 CLK = ~CLK;
    always @(posedge CLK) begin
        if (SPEED_PULSE_OUT === 1'b1) begin
            pulses <= pulses + 1;
        end
    end
    // short duty steps: both startups together need about 35k cycles
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 50000) begin
            mismatches++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLK);
        end while (PREADY !== 1'b1);
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic wait_st(input logic [6:0] s, input int lim);
        n = 0;
        while (SEQ_STATE !== s && n < lim) begin
            @(posedge CLK);
            n++;
        end
    endtask
    task automatic count(input int exp);
        int p;
        p = pulses;
        repeat (600) @(posedge CLK);
        chk(32'(pulses - p), 32'(exp));
    endtask

    initial begin
        repeat (16) @(posedge CLK);
        RST_B <= 1'b1;
        SPEED_VOLTAGE_IN <= 10'd200;
        chk(32'(SEQ_STATE), 32'(S_OFF));
        chk(32'(DRIVE.all_off), 32'h1);
        apb(1'b1, STATUS_OFS, '1);
        apb(1'b0, STATUS_OFS, '0);
        chk(rd, 32'h0000_0101);
        apb(1'b0, 8'h18, '0);
        chk({rd[30:0], er}, 32'h0000_0001);
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, ofs[i], '0);
            chk(rd, rst_v[i]);
            apb(1'b1, ofs[i], '1);
            apb(1'b0, ofs[i], '0);
            chk(rd, msk[i]);
        end
        apb(1'b1, LEVEL_CFG_OFS, LEVEL_CFG_RST);
        apb(1'b1, START_CFG_OFS, 32'h0011_041F);
        apb(1'b1, SPEED_CFG_OFS, 32'h0006_0643);
        apb(1'b0, REF_SPD_OFS, '0);
        chk(rd, 32'h0000_0258);
        apb(1'b1, SPEED_CFG_OFS, 32'h0007_0643);
        apb(1'b0, REF_SPD_OFS, '0);
        chk(rd, 32'h0000_012C);
        apb(1'b1, RUN_CTRL_OFS, 32'h0000_0005);
        repeat (500) @(posedge CLK);
        chk(32'({SEQ_STATE, DRIVE.all_off}), 32'h03);
        wait_st(S_BOOT, 1000);
        chk(32'(SEQ_STATE), 32'(S_BOOT));
        wait_st(S_WMBRK, 100);
        chk(32'(SEQ_STATE), 32'(S_WMBRK));
        repeat (3000) @(posedge CLK);
        d0 = DRIVE.low_duty;
        overload <= 1'b1;
        repeat (2500) @(posedge CLK);
        chk(32'(DRIVE.low_duty > d0), 32'h0);
        chk(32'(DRIVE.low_brake), 32'h1);
        overload <= 1'b0;
        n = 0;
        while (DRIVE.low_duty !== DUTY_FULL && n < 20000) begin
            @(posedge CLK);
            n++;
        end
        chk(32'(SEQ_STATE), 32'(S_WMBRK));
        wait_st(S_DRIVE, 1000);
        chk(32'(SEQ_STATE), 32'(S_DRIVE));
        chk(32'(MOTOR_CURRENT), 32'h0);
        @(posedge CLK);
        chk(32'({DRIVE.open_loop, DRIVE.excite_speed}), 32'h4020);
        wait_st(S_RUN, 4000);
        chk(32'(n > 3000 && n < 3110), 32'h1);
        chk(32'({DRIVE.open_loop, DRIVE.excite_speed}), 32'h012C);
        chk(32'(DRIVE.torque), 32'h0000_1000);
        repeat (10) @(posedge CLK);
        t0 = 32'(DRIVE.torque);
        repeat (1000) @(posedge CLK);
        chk(32'(DRIVE.torque) - t0, (32'h12C - 32'(FEEDBACK_SPEED)) * 20);
        for (int i = 0; i < 4; i++) begin
            DIR_PIN <= i[0];
            apb(1'b1, RUN_CTRL_OFS, 32'h5 | (32'(i[1]) << 1));
            repeat (3) @(posedge CLK);
            chk(32'(DRIVE.reverse), 32'(i[0] ^ i[1]));
        end
        count(12);
        apb(1'b1, SPEED_CFG_OFS, 32'h0005_0643);
        repeat (10) @(posedge CLK);
        count(4);
        lose_sync <= 1'b1;
        repeat (10) @(posedge CLK);
        count(0);
        apb(1'b1, RUN_CTRL_OFS, 32'h0);
        repeat (2) @(posedge CLK);
        chk(32'({SEQ_STATE, DRIVE.all_off}), 32'h03);
        chk(32'(DRIVE.torque), 32'h0000_0000);
        // second start: speed voltage source, in brake range, alignment
        SPEED_VOLTAGE_IN <= 10'd16;
        apb(1'b1, SPEED_CFG_OFS, 32'h0006_0643);
        apb(1'b1, RUN_CTRL_OFS, 32'h0000_0001);
        wait_st(S_UCBRK, 2000);
        chk(32'({SEQ_STATE, DRIVE.low_brake}), 32'h05);
        SPEED_VOLTAGE_IN <= 10'd200;
        wait_st(S_HOLD, 15000);
        chk(32'(SEQ_STATE), 32'(S_HOLD));
        wait_st(S_RUN, 2000);
        chk(32'(n > 1500 && n < 1700), 32'h1);
        chk(32'(DRIVE.torque), 32'h0000_1000);
        test_done();
    end
endmodule // testbench
`default_nettype wire
